// *** rtl/acp_pkg.sv ***
// Package of constants for the converter control-pin logic
package acp_pkg;
    localparam int unsigned WORD_BITS   = 24;
    localparam int unsigned CNT_W       = 5;
    localparam int unsigned AUX1_POS    = 4;
    localparam int unsigned AUX0_POS    = 3;
    localparam int unsigned CMD_BITS    = 8;
    // Master clock nominal rates in kHz
    localparam int unsigned MCLK_LO_KHZ  = 1024;
    localparam int unsigned MCLK_HI_KHZ  = 2458;
    localparam int unsigned SYS_CLK_MHZ  = 100;
    localparam int unsigned SYS_CLK_KHZ  = SYS_CLK_MHZ * 1000;
    // Period of the slowest nominal master clock, in system cycles
    localparam int unsigned MCLK_TMO_CYC = SYS_CLK_KHZ / MCLK_LO_KHZ;
    // Shortest undoubled master period, in system cycles
    localparam int unsigned MCLK_MIN_PER = SYS_CLK_KHZ / 5000;
    localparam logic [1:0] PAIR_PSEUDO  = 2'h0;
    localparam logic [1:0] PAIR_DIFF    = 2'h1;
    localparam logic [2:0] CH_DIFF_MAX  = 3'h2;
    localparam logic [2:0] CH_PSEUDO_MAX = 3'h4;
    localparam logic [2:0] CH_GAIN_CAL  = 3'h5;
    localparam logic [7:0] SEL_RESET    = 8'h00;

    typedef enum logic [1:0] {
        ACP_IDLE = 2'h0,
        ACP_CMD  = 2'h1,
        ACP_READ = 2'h2
    } acp_state_e;
endpackage

// *** rtl/acp_ctrl.sv ***
// Control-pin logic: select, reset exit, aux status capture, data ready, input mux
module acp_ctrl
    import acp_pkg::*;
(
    // System
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    // Master clock and its rate select
    input  wire logic                  i_master_clock_in,
    input  wire logic                  i_clock_double_sel,
    // Serial port
    input  wire logic                  i_cs_n,
    input  wire logic                  i_sclk,
    input  wire logic                  i_din,
    output logic                       o_dout,
    output logic                       o_dout_oe,
    // Auxiliary status pins
    input  wire logic                  i_aux_status_in1,
    input  wire logic                  i_aux_status_in0,
    // Conversion result
    input  wire logic                  i_word_valid,
    input  wire logic [WORD_BITS-1:0]  i_word,
    output logic                       o_data_ready_n,
    // Input switch control
    input  wire logic                  i_pair_mode,
    input  wire logic                  i_auto_seq,
    input  wire logic                  i_gain_cal_used,
    input  wire logic                  i_seq_step,
    output logic [2:0]                 o_channel,
    output logic [2:0]                 o_pos_sel,
    output logic [2:0]                 o_neg_sel,
    output logic                       o_gain_cal_sel,
    // Status
    output logic                       o_in_reset,
    output logic                       o_clock_rate_err
);
    // Two-flop reset release
    logic [1:0] rst_sync_reg;
    logic       rst_run_n;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            rst_sync_reg <= 2'h0;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // Pin synchronisers: first flop feeds only the second
    logic [1:0] mclk_s_reg, cs_s_reg, sclk_s_reg, din_s_reg, a1_s_reg, a0_s_reg;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mclk_s_reg <= 2'h0;
            cs_s_reg   <= 2'h3;
            sclk_s_reg <= 2'h3;
            din_s_reg  <= 2'h0;
            a1_s_reg   <= 2'h0;
            a0_s_reg   <= 2'h0;
        end
        else
        begin
            mclk_s_reg <= {mclk_s_reg[0], i_master_clock_in};
            cs_s_reg   <= {cs_s_reg[0], i_cs_n};
            sclk_s_reg <= {sclk_s_reg[0], i_sclk};
            din_s_reg  <= {din_s_reg[0], i_din};
            a1_s_reg   <= {a1_s_reg[0], i_aux_status_in1};
            a0_s_reg   <= {a0_s_reg[0], i_aux_status_in0};
        end
    end

    // Master clock activity and rate watch
    logic        mclk_d_reg, mclk_d_next;
    logic        mclk_ok_reg, mclk_ok_next;
    logic [15:0] mclk_cnt_reg, mclk_cnt_next;
    logic        rate_err_reg, rate_err_next;
    logic        mclk_edge;
    logic [15:0] half_min;
    always_comb
    begin
        mclk_d_next   = mclk_s_reg[1];
        mclk_edge     = mclk_s_reg[1] & ~mclk_d_reg;
        // Fastest undoubled rate: a full period must exceed this count
        half_min      = i_clock_double_sel ? 16'h0000 : 16'(MCLK_MIN_PER);
        mclk_cnt_next = mclk_cnt_reg;
        mclk_ok_next  = mclk_ok_reg;
        rate_err_next = rate_err_reg;
        if (mclk_edge)
        begin
            mclk_cnt_next = 16'h0000;
            mclk_ok_next  = 1'b1;
            rate_err_next = mclk_cnt_reg < half_min;
        end
        else if (mclk_cnt_reg >= 16'(MCLK_TMO_CYC * 2))
            mclk_ok_next = 1'b0;
        else
            mclk_cnt_next = mclk_cnt_reg + 16'h0001;
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            mclk_d_reg   <= 1'b0;
            mclk_cnt_reg <= 16'h0000;
            mclk_ok_reg  <= 1'b0;
            rate_err_reg <= 1'b0;
        end
        else
        begin
            mclk_d_reg   <= mclk_d_next;
            mclk_cnt_reg <= mclk_cnt_next;
            mclk_ok_reg  <= mclk_ok_next;
            rate_err_reg <= rate_err_next;
        end
    end

    // Run only with reset released and master clock toggling
    assign rst_run_n        = rst_sync_reg[1] & mclk_ok_reg;
    assign o_in_reset       = ~rst_run_n;
    assign o_clock_rate_err = rate_err_reg;

    // Serial engine
    acp_state_e             st_reg, st_next;
    logic                   sclk_d_reg, cs_d_reg;
    logic [CNT_W-1:0]       cnt_reg, cnt_next;
    logic [CMD_BITS-1:0]    cmd_reg, cmd_next;
    logic [WORD_BITS-1:0]   sh_reg, sh_next;
    logic [WORD_BITS-1:0]   word_reg, word_next;
    logic                   rdy_n_reg, rdy_n_next;
    logic                   dout_reg, dout_next;
    logic                   sel, fall, rise, cs_fall;
    always_comb
    begin
        sel        = ~cs_s_reg[1];
        fall       = sclk_d_reg & ~sclk_s_reg[1];
        rise       = ~sclk_d_reg & sclk_s_reg[1];
        cs_fall    = cs_d_reg & ~cs_s_reg[1];
        st_next    = st_reg;
        cnt_next   = cnt_reg;
        cmd_next   = cmd_reg;
        sh_next    = sh_reg;
        word_next  = word_reg;
        rdy_n_next = rdy_n_reg;
        dout_next  = dout_reg;
        if (i_word_valid)
        begin
            word_next  = i_word;
            rdy_n_next = 1'b0;
        end
        if (!sel)
            st_next = ACP_IDLE;
        else if (cs_fall)
        begin
            st_next  = ACP_CMD;
            cnt_next = '0;
        end
        else
        begin
            case (st_reg)
                ACP_IDLE:
                begin
                    // Select held low: next rising edge starts a command (3-wire)
                    if (rise)
                    begin
                        st_next  = ACP_CMD;
                        cmd_next = {cmd_reg[CMD_BITS-2:0], din_s_reg[1]};
                        cnt_next = CNT_W'(1);
                    end
                end
                ACP_CMD:
                begin
                    if (rise)
                    begin
                        cmd_next = {cmd_reg[CMD_BITS-2:0], din_s_reg[1]};
                        cnt_next = cnt_reg + CNT_W'(1);
                        if (cnt_reg == CNT_W'(CMD_BITS - 1))
                        begin
                            cnt_next = '0;
                            // Command LSB high requests a data read
                            st_next  = din_s_reg[1] ? ACP_READ : ACP_IDLE;
                        end
                    end
                end
                ACP_READ:
                begin
                    if (fall)
                    begin
                        if (cnt_reg == '0)
                        begin
                            // Aux pins latched on first falling edge
                            sh_next = word_reg;
                            sh_next[AUX1_POS] = a1_s_reg[1];
                            sh_next[AUX0_POS] = a0_s_reg[1];
                            dout_next = sh_next[WORD_BITS-1];
                        end
                        else
                            dout_next = sh_reg[WORD_BITS-1-int'(cnt_reg)];
                    end
                    if (rise)
                    begin
                        cnt_next = cnt_reg + CNT_W'(1);
                        if (cnt_reg == CNT_W'(WORD_BITS - 1))
                        begin
                            st_next  = ACP_IDLE;
                            cnt_next = '0;
                            if (!i_word_valid)
                                rdy_n_next = 1'b1;
                        end
                    end
                end
                default: st_next = ACP_IDLE;
            endcase
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_reg     <= ACP_IDLE;
            sclk_d_reg <= 1'b1;
            cs_d_reg   <= 1'b1;
            cnt_reg    <= '0;
            cmd_reg    <= '0;
            sh_reg     <= '0;
            word_reg   <= '0;
            rdy_n_reg  <= 1'b1;
            dout_reg   <= 1'b0;
        end
        else if (!rst_run_n)
        begin
            st_reg     <= ACP_IDLE;
            sclk_d_reg <= sclk_s_reg[1];
            cs_d_reg   <= cs_s_reg[1];
            cnt_reg    <= '0;
            cmd_reg    <= '0;
            sh_reg     <= '0;
            word_reg   <= '0;
            rdy_n_reg  <= 1'b1;
            dout_reg   <= 1'b0;
        end
        else
        begin
            st_reg     <= st_next;
            sclk_d_reg <= sclk_s_reg[1];
            cs_d_reg   <= cs_s_reg[1];
            cnt_reg    <= cnt_next;
            cmd_reg    <= cmd_next;
            sh_reg     <= sh_next;
            word_reg   <= word_next;
            rdy_n_reg  <= rdy_n_next;
            dout_reg   <= dout_next;
        end
    end
    assign o_dout         = dout_reg;
    assign o_dout_oe      = (st_reg == ACP_READ) & sel;
    assign o_data_ready_n = rdy_n_reg;

    // Input switch: channel index walks on each step in auto-sequence
    logic [2:0] ch_reg, ch_next;
    logic [2:0] ch_max;
    always_comb
    begin
        ch_max  = (i_pair_mode == PAIR_DIFF[0]) ? CH_DIFF_MAX : CH_PSEUDO_MAX;
        ch_next = ch_reg;
        if (i_auto_seq && i_seq_step)
        begin
            if (ch_reg == ch_max && !i_gain_cal_used)
                ch_next = CH_GAIN_CAL;
            else if (ch_reg >= ch_max)
                ch_next = 3'h0;
            else
                ch_next = ch_reg + 3'h1;
        end
    end
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ch_reg <= 3'h0;
        else if (!rst_run_n)
            ch_reg <= 3'h0;
        else
            ch_reg <= ch_next;
    end
    // Pins coded 0..5 for analog_in_1..analog_in_5 and analog_common_in
    always_comb
    begin
        o_channel      = ch_reg;
        o_gain_cal_sel = (ch_reg == CH_GAIN_CAL);
        if (o_gain_cal_sel)
        begin
            o_pos_sel = 3'h0;
            o_neg_sel = 3'h0;
        end
        else if (i_pair_mode == PAIR_DIFF[0])
        begin
            o_pos_sel = 3'(ch_reg * 2);
            o_neg_sel = 3'(ch_reg * 2 + 1);
        end
        else
        begin
            o_pos_sel = ch_reg;
            o_neg_sel = 3'h5;
        end
    end
endmodule

// *** bench/acp_ctrl_asserts.sv ***
// Checker of the control-pin logic ports
module acp_ctrl_asserts
    import acp_pkg::*;
(
    // System
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_master_clock_in,
    // Serial port and status
    input wire logic       i_cs_n,
    input wire logic       o_dout_oe,
    input wire logic       o_data_ready_n,
    input wire logic       o_in_reset,
    // Input switch
    input wire logic       i_pair_mode,
    input wire logic       i_gain_cal_used,
    input wire logic [2:0] o_channel,
    input wire logic [2:0] o_pos_sel,
    input wire logic [2:0] o_neg_sel,
    input wire logic       o_gain_cal_sel
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // Cycles the master clock has stood still; a wrap only hides, never fires
    logic [8:0] still_reg;
    logic [8:0] still_next;
    logic       mck_reg;
    always_comb still_next = (i_master_clock_in != mck_reg) ? 9'h0 : still_reg + 9'h1;
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
        if (!i_rst_n)
            still_reg <= 9'h0;
        else
            still_reg <= still_next;
    always_ff @(posedge i_sys_clk)
        mck_reg <= i_master_clock_in;
    property p_oe_drop; $rose(i_cs_n) |-> ##[0:5] !o_dout_oe; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("dout enable after deselect");
    // Registers clear one edge after the internal hold starts
    property p_rst_quiet;
        o_in_reset && $past(o_in_reset) |-> o_data_ready_n && !o_dout_oe;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
    property p_rst_sync; $rose(i_rst_n) |-> o_in_reset [*2]; endproperty
    a_rst_sync: assert property (p_rst_sync) else $error("reset exit too early");
    property p_mclk; $fell(o_in_reset) |-> still_reg < 9'hc8; endproperty
    a_mclk: assert property (p_mclk) else $error("reset left without master clock");
    property p_rdy; $rose(o_data_ready_n) |-> $past(o_dout_oe) || $past(o_dout_oe, 2); endproperty
    a_rdy: assert property (p_rdy) else $error("ready cleared without a read");
    property p_psd;
        !i_pair_mode && $stable(i_pair_mode) && !o_gain_cal_sel
            |-> o_pos_sel == o_channel && o_neg_sel == 3'h5;
    endproperty
    a_psd: assert property (p_psd) else $error("pseudo pairing wrong");
    property p_dif;
        i_pair_mode && $stable(i_pair_mode) && !o_gain_cal_sel
            |-> o_pos_sel == {o_channel[1:0], 1'b0} && o_neg_sel == o_pos_sel + 3'h1;
    endproperty
    a_dif: assert property (p_dif) else $error("differential pairing wrong");
    // Gain pair only follows the last signal channel, and only when free
    property p_gain;
        $rose(o_gain_cal_sel) |-> !i_gain_cal_used
            && $past(o_channel) == (i_pair_mode ? CH_DIFF_MAX : CH_PSEUDO_MAX);
    endproperty
    a_gain: assert property (p_gain) else $error("gain pair select wrong");
    c_read: cover property ($rose(o_data_ready_n));
    c_gain: cover property ($rose(o_gain_cal_sel));
    c_exit: cover property ($fell(o_in_reset));
endmodule
bind acp_ctrl acp_ctrl_asserts chk_inst (.i_sys_clk, .i_rst_n, .i_master_clock_in, .i_cs_n,
    .o_dout_oe, .o_data_ready_n, .o_in_reset, .i_pair_mode, .i_gain_cal_used, .o_channel, .o_pos_sel,
    .o_neg_sel, .o_gain_cal_sel);

// *** bench/acp_host.sv ***
// Host model: serial master framing with select, plus aux status pins
module acp_host (
    // Serial port
    output logic      o_cs_n,
    output logic      o_sclk,
    output logic      o_din,
    input  wire logic i_dout,
    input  wire logic i_dout_oe,
    // Aux status pins
    output logic      o_aux1,
    output logic      o_aux0
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam realtime HALF = 62.5;
    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_din = 1'b0;
        {o_aux1, o_aux0} = 2'h0;
    end
    // Clock idles high so a select left low stays legal
    task automatic xfer(input logic [7:0] cmd, input int nrd, input logic [1:0] aux,
                        input bit keep, output logic [23:0] rd);
        rd = 24'h0;
        {o_aux1, o_aux0} = aux;
        #HALF o_cs_n = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            #HALF o_sclk = 1'b0;
            o_din = cmd[i];
            #HALF o_sclk = 1'b1;
        end
        for (int i = 0; i < nrd; i++)
        begin
            #HALF o_sclk = 1'b0;
            o_din = ~o_din;
            #HALF o_sclk = 1'b1;
            rd = {rd[22:0], i_dout_oe ? i_dout : 1'bx};
            {o_aux1, o_aux0} = ~aux;
        end
        #HALF o_din = ~o_din;
        if (!keep)
            o_cs_n = 1'b1;
    endtask
endmodule

// *** bench/acp_ctrl_tb.sv ***
// Self-checking bench for the control-pin logic
module acp_ctrl_tb
    import acp_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_master_clock_in = 1'b0, i_seq_step = 1'b0;
    logic i_clock_double_sel = 1'b0, i_word_valid = 1'b0, i_pair_mode = 1'b0;
    logic i_auto_seq = 1'b0, i_gain_cal_used = 1'b0;
    logic i_cs_n, i_sclk, i_din, i_aux_status_in1, i_aux_status_in0, o_dout, o_dout_oe;
    logic o_data_ready_n, o_gain_cal_sel, o_in_reset, o_clock_rate_err;
    logic [2:0]           o_channel, o_pos_sel, o_neg_sel;
    logic [WORD_BITS-1:0] i_word = 24'h0, w, rd;
    logic [15:0]          lfsr = 16'h3dd4;
    int                   err_count = 0, tests_run = 0, cycles = 0, n, e;
    realtime              m_half = 488.0;
    bit                   m_run = 1'b0;
    initial forever #5 i_sys_clk = ~i_sys_clk;
    initial forever #(m_half) if (m_run) i_master_clock_in = ~i_master_clock_in;
    acp_ctrl acp_ctrl_inst (.i_sys_clk, .i_rst_n, .i_master_clock_in, .i_clock_double_sel,
        .i_cs_n, .i_sclk, .i_din, .o_dout, .o_dout_oe, .i_aux_status_in1, .i_aux_status_in0,
        .i_word_valid, .i_word, .o_data_ready_n, .i_pair_mode, .i_auto_seq, .i_gain_cal_used,
        .i_seq_step, .o_channel, .o_pos_sel, .o_neg_sel, .o_gain_cal_sel, .o_in_reset,
        .o_clock_rate_err);
    acp_host acp_host_inst (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din), .i_dout(o_dout),
        .i_dout_oe(o_dout_oe), .o_aux1(i_aux_status_in1), .o_aux0(i_aux_status_in0));
    task automatic cyc(input int k);
        repeat (k) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Errors %0d, checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic step_rand();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    endtask
    // Fresh result, ready must drop
    task automatic new_word();
        step_rand();
        w[23:16] = lfsr[7:0];
        step_rand();
        w[15:0] = lfsr;
        i_word = w;
        i_word_valid = 1'b1;
        cyc(1);
        i_word_valid = 1'b0;
        cyc(3);
        check(24'(o_data_ready_n), 24'h0);
    endtask
    task automatic pulse_step();
        i_seq_step = 1'b1;
        cyc(1);
        i_seq_step = 1'b0;
        cyc(3);
    endtask
    always @(posedge i_sys_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            err_count++;
            close_out();
        end
    end
    initial
    begin
        cyc(20);
        i_rst_n = 1'b1;
        cyc(300);
        check(24'(o_in_reset), 24'h1);
        m_run = 1'b1;
        cyc(400);
        check(24'(o_in_reset), 24'h0);
        for (int k = 0; k < 4; k++)
        begin
            new_word();
            acp_host_inst.xfer(8'h01, 24, k[1:0], k == 1, rd);
            cyc(6);
            check(rd, {w[23:5], k[1:0], w[2:0]});
            check(24'(o_data_ready_n), 24'h1);
        end
        new_word();
        acp_host_inst.xfer(8'h01, 10, 2'h2, 1'b0, rd);
        cyc(6);
        check(24'({o_dout_oe, o_data_ready_n}), 24'h0);
        acp_host_inst.xfer(8'h00, 0, 2'h2, 1'b0, rd);
        cyc(6);
        check(24'({o_dout_oe, o_data_ready_n}), 24'h0);
        acp_host_inst.xfer(8'h01, 24, 2'h1, 1'b0, rd);
        cyc(6);
        check(rd, {w[23:5], 2'h1, w[2:0]});
        m_half = 60.0;
        cyc(100);
        check(24'(o_clock_rate_err), 24'h1);
        i_clock_double_sel = 1'b1;
        cyc(100);
        check(24'(o_clock_rate_err), 24'h0);
        m_half = 488.0;
        i_clock_double_sel = 1'b0;
        i_auto_seq = 1'b1;
        for (int m = 0; m < 4; m++)
        begin
            i_pair_mode = m[1];
            i_gain_cal_used = m[0];
            n = m[1] ? 3 : 5;
            for (int s = 1; s <= n + 1 - int'(m[0]); s++)
            begin
                pulse_step();
                e = s < n ? s : (s == n && !m[0] ? 5 : 0);
                check(24'(o_channel), 24'(e));
                check(24'({o_gain_cal_sel, o_pos_sel, o_neg_sel}), (e == 5) ? 24'h40 : m[1] ? 24'({1'b0, 3'(e * 2), 3'(e * 2 + 1)}) : 24'({1'b0, 3'(e), 3'h5}));
            end
        end
        pulse_step();
        new_word();
        i_rst_n = 1'b0;
        cyc(2);
        check(24'({o_in_reset, o_data_ready_n, o_dout_oe, o_channel}), 24'h30);
        i_rst_n = 1'b1;
        cyc(400);
        check(24'(o_in_reset), 24'h0);
        close_out();
    end
endmodule
